//--- sas_sequencer.sv
// Top of the converter sequencer: Avalon-MM registers and analog pins.
// Assumes the comparator is driven from this clock's flops and settles in one clock.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module sas_sequencer
    import sas_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    // Avalon-MM slave
    input  wire logic [3:0] avs_address,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic [31:0]     avs_readdata,
    output logic            avs_waitrequest,
    // Analog front end
    input  wire logic       cmp_above,
    output logic            sample_en,
    output logic [7:0]      trial_code,
    output logic [3:0]      input_select,
    output logic            converter_power_on
);
    typedef struct packed {
        logic        done;
        logic        on;
        logic [3:0]  sel;
        logic        halt;
        logic        wait_mode;
        logic [7:0]  stab;
        logic        ack;
        logic [31:0] rdata;
        logic        restart;
        logic        sample;
        logic [7:0]  code;
        logic        pwr;
    } sas_top_s;
    sas_top_s s_q;
    sas_top_s s_d;

    sas_sar_if sar ();
    logic       eng_sample;
    logic [7:0] eng_code;
    logic       wr_hit;
    logic       rd_hit;
    logic [7:0] csr_view;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = a == off;
    endfunction

    // No synchroniser: its latency would not fit a two-clock approximation step
    sas_sar_engine u_eng (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .bus        (sar),
        .cmp_above  (cmp_above),
        .sample_en  (eng_sample),
        .trial_code (eng_code)
    );

    // Halt gates the engine; wait mode is deliberately not looked at
    assign sar.run     = s_q.on & ~s_q.halt;
    assign sar.restart = s_q.restart;

    // One access per two cycles: request, then acknowledge
    assign wr_hit = avs_write & ~s_q.ack;
    assign rd_hit = avs_read & ~s_q.ack;
    assign csr_view = {s_q.done, 1'b0, s_q.on, 1'b0, s_q.sel};

    always_comb
    begin
        s_d = s_q;
        s_d.ack = (avs_read | avs_write) & ~s_q.ack;
        s_d.restart = 1'b0;
        if (rd_hit && hit(avs_address, SAS_OFF_RESULT))
            s_d.done = 1'b0;
        if (wr_hit && hit(avs_address, SAS_OFF_CSR))
        begin
            // Reserved positions are not stored, whatever software writes
            s_d.on = avs_writedata[SAS_BIT_ON];
            s_d.sel = avs_writedata[SAS_SEL_LSB +: SAS_SEL_W];
            s_d.restart = avs_writedata[SAS_BIT_ON] & s_q.on;
            s_d.done = 1'b0;
        end
        // Set after the clears, so a finishing conversion is never lost
        if (sar.done)
            s_d.done = 1'b1;
        if (wr_hit && hit(avs_address, SAS_OFF_POWER))
        begin
            s_d.halt = avs_writedata[SAS_BIT_HALT];
            s_d.wait_mode = avs_writedata[SAS_BIT_WAIT];
            if (s_q.halt && !avs_writedata[SAS_BIT_HALT])
                s_d.stab = SAS_STAB_CNT;
        end
        if (s_q.stab != 8'h00 && !s_q.halt)
            s_d.stab = s_q.stab - 8'h01;
        if (rd_hit)
        begin
            case (avs_address)
                SAS_OFF_RESULT: s_d.rdata = {24'h000000, sar.result};
                SAS_OFF_CSR:    s_d.rdata = {24'h000000, csr_view};
                SAS_OFF_POWER:  s_d.rdata = {22'h000000, s_q.stab != 8'h00, 7'h00,
                                             s_q.wait_mode, s_q.halt};
                default:        s_d.rdata = 32'h00000000;
            endcase
        end
        s_d.sample = eng_sample;
        s_d.code = eng_code;
        s_d.pwr = sar.run;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
            s_q.done <= SAS_CSR_RST[SAS_BIT_DONE];
            s_q.on <= SAS_CSR_RST[SAS_BIT_ON];
        end
        else
            s_q <= s_d;
    end

    // No interrupt output exists: software polls the done flag
    assign avs_readdata       = s_q.rdata;
    assign avs_waitrequest    = ~s_q.ack;
    assign sample_en          = s_q.sample;
    assign trial_code         = s_q.code;
    assign input_select       = s_q.sel;
    assign converter_power_on = s_q.pwr;
endmodule
`default_nettype wire

//--- sas_pkg.sv
// Package for the converter sequencer: register map, fields, timing.
// Assumes a 250 MHz system clock and an Avalon-MM byte-addressed slave.
package sas_pkg;
    // Register byte offsets (one aligned word each)
    localparam logic [3:0] SAS_OFF_RESULT = 4'h0;
    localparam logic [3:0] SAS_OFF_CSR    = 4'h4;
    localparam logic [3:0] SAS_OFF_POWER  = 4'h8;
    // Control/status field positions
    localparam int SAS_BIT_DONE = 7;
    localparam int SAS_BIT_ON   = 5;
    localparam int SAS_SEL_LSB  = 0;
    localparam int SAS_SEL_W    = 4;
    // Power mode register field positions
    localparam int SAS_BIT_HALT = 0;
    localparam int SAS_BIT_WAIT = 1;
    // Reset values
    localparam logic [7:0] SAS_CSR_RST    = 8'h00;
    localparam logic [7:0] SAS_RESULT_RST = 8'h00;
    // Timing: converter clock is system clock over two
    localparam int SAS_CLK_DIV      = 2;
    localparam int SAS_CONV_PERIODS = 12;
    localparam int SAS_SAR_BITS     = 8;
    localparam int SAS_LOAD_PERIODS = SAS_CONV_PERIODS - SAS_SAR_BITS;
    // Stabilisation after wake from halt
    localparam int SAS_STAB_NS      = 1000;
    localparam int SAS_CLK_MHZ      = 250;
    localparam int SAS_STAB_CYCLES  = (SAS_STAB_NS * SAS_CLK_MHZ + 999) / 1000;
    localparam logic [7:0] SAS_STAB_CNT = 8'(SAS_STAB_CYCLES);
    typedef enum logic [1:0] {SAS_IDLE, SAS_LOAD, SAS_SAR} sas_phase_e;
endpackage

//--- sas_sar_if.sv
// Interface between the register front end and the conversion engine.
// Assumes both ends sit on clk_sys.
`timescale 1ns/1ns
`default_nettype none
interface sas_sar_if;
    logic       run;
    logic       restart;
    logic [7:0] result;
    logic       done;
    modport ctrl (output run, output restart, input result, input done);
    modport eng  (input run, input restart, output result, output done);
endinterface
`default_nettype wire

//--- sas_sar_engine.sv
// Successive-approximation conversion engine.
// Assumes the comparator answer settles within one clock of trial_code.
`timescale 1ns/1ns
`default_nettype none
module sas_sar_engine
    import sas_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Control
    sas_sar_if.eng    bus,
    // Analog side
    input  wire logic cmp_above,
    output logic      sample_en,
    output logic [7:0] trial_code
);
    typedef struct packed {
        sas_phase_e phase;
        logic       tick;
        logic [3:0] cnt;
        logic [7:0] code;
        logic [7:0] result;
        logic       done;
    } sas_eng_s;
    sas_eng_s s_q;
    sas_eng_s s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.tick = ~s_q.tick;
        if (!bus.run)
        begin
            s_d.phase = SAS_IDLE;
            s_d.tick = 1'b0;
        end
        else if (bus.restart || s_q.phase == SAS_IDLE)
        begin
            s_d.phase = SAS_LOAD;
            s_d.cnt = 4'h0;
            s_d.tick = 1'b0;
        end
        else if (s_q.tick)
        begin
            case (s_q.phase)
                SAS_LOAD:
                begin
                    if (s_q.cnt == 4'(SAS_LOAD_PERIODS - 1))
                    begin
                        s_d.phase = SAS_SAR;
                        s_d.cnt = 4'h0;
                        s_d.code = 8'h80;
                    end
                    else
                        s_d.cnt = s_q.cnt + 4'h1;
                end
                SAS_SAR:
                begin
                    // One bit resolved per converter period, MSB first
                    if (!cmp_above)
                        s_d.code[3'(7 - s_q.cnt)] = 1'b0;
                    if (s_q.cnt != 4'(SAS_SAR_BITS - 1))
                        s_d.code[3'(6 - s_q.cnt)] = 1'b1;
                    if (s_q.cnt == 4'(SAS_SAR_BITS - 1))
                    begin
                        s_d.result = {s_q.code[7:1], s_q.code[0] & cmp_above};
                        s_d.done = 1'b1;
                        s_d.phase = SAS_LOAD;
                        s_d.cnt = 4'h0;
                    end
                    else
                        s_d.cnt = s_q.cnt + 4'h1;
                end
                default:
                    s_d.phase = SAS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
            s_q.phase <= SAS_IDLE;
            s_q.result <= SAS_RESULT_RST;
        end
        else
            s_q <= s_d;
    end

    // Saturation at the rails falls out of the comparator staying one way
    assign bus.result = s_q.result;
    assign bus.done   = s_q.done;
    assign sample_en  = s_q.phase == SAS_LOAD;
    assign trial_code = s_q.code;
endmodule
`default_nettype wire

//--- sas_cmp_model.sv
// Comparator and input mux model for the sequencer's analog side.
// Assumes the bench sets one level per input channel.
`timescale 1ns/1ns
`default_nettype none
module sas_cmp_model
(
    // Converter side
    input  wire logic       clk_sys,
    input  wire logic       sample_en,
    input  wire logic [7:0] trial_code,
    input  wire logic [3:0] input_select,
    output logic            cmp_above
);
    logic [7:0] level [16];
    logic [7:0] held = 8'h00;
    // Capacitor follows the selected input only while loading
    always @(posedge clk_sys)
        if (sample_en)
            held <= level[input_select];
    // Half-step offset keeps decisions free of ties
    assign cmp_above = {held, 1'b1} > {trial_code, 1'b0};
endmodule
`default_nettype wire

//--- sas_sequencer_asserts.sv
// Checker for the converter sequencer top ports.
// Assumes writes and halt are the only ways a conversion is cut short.
`timescale 1ns/1ns
`default_nettype none
module sas_sequencer_asserts
    import sas_pkg::*;
(
    // Clock, bus, analog
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        cmp_above,
    input wire logic        sample_en,
    input wire logic [7:0]  trial_code,
    input wire logic [3:0]  input_select,
    input wire logic        converter_power_on
);
    logic [2:0] wr_q;
    logic       smp_q;
    logic [5:0] per_q;
    logic       per_v_q;
    wire        quiet = (wr_q == 3'h0) && !avs_write;
    wire        csr_ack = avs_write && !avs_waitrequest && avs_address == SAS_OFF_CSR;
    // Period is only judged between rises with no write in between
    always_ff @(posedge clk_sys)
    begin
        smp_q   <= reset_n & sample_en;
        wr_q    <= reset_n ? {wr_q[1:0], avs_write} : 3'h0;
        per_q   <= (sample_en && !smp_q) ? 6'h01 : per_q + 6'h01;
        per_v_q <= reset_n && converter_power_on && !avs_write
                   && ((sample_en && !smp_q) || per_v_q);
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    period_len_a: assert property ($rose(sample_en) && per_v_q |-> per_q == 6'h18)
        else $error("conversion period not 24 clocks");
    load_len_a: assert property ($fell(sample_en) && quiet |-> $past(sample_en, 8))
        else $error("load phase shorter than 8 clocks");
    msb_first_a: assert property ($fell(sample_en) && quiet |-> ##[0:2] trial_code == 8'h80)
        else $error("first trial code not 80");
    step_hold_a: assert property ($changed(trial_code) && !sample_en && quiet
        |=> $stable(trial_code) || sample_en) else $error("trial step under 2 clocks");
    off_quiet_a: assert property ($fell(converter_power_on) |-> ##2 (!sample_en)[*8])
        else $error("sampling while switched off");
    start_on_a: assert property (csr_ack && avs_writedata[SAS_BIT_ON] |-> ##[1:6] sample_en)
        else $error("no load after on write");
    rsv_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == SAS_OFF_CSR
        |-> avs_readdata[6] == 1'b0 && avs_readdata[4] == 1'b0) else $error("reserved bit set");
    sel_follow_a: assert property (csr_ack |=> input_select == $past(avs_writedata[3:0]))
        else $error("select not following write");
endmodule
bind sas_sequencer sas_sequencer_asserts sas_sequencer_asserts_i (.clk_sys(clk_sys),
    .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmp_above(cmp_above), .sample_en(sample_en),
    .trial_code(trial_code), .input_select(input_select),
    .converter_power_on(converter_power_on));
`default_nettype wire

//--- sas_sequencer_tb.sv
// Self-checking bench for the converter sequencer.
// Assumes the comparator model answers within one clock.
`timescale 1ns/1ns
`default_nettype none
module sas_sequencer_tb
    import sas_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic        avs_waitrequest, cmp_above, sample_en, converter_power_on;
    logic [7:0]  trial_code, lv;
    logic [3:0]  input_select;
    int          err_total = 0, comparisons = 0, seed = 32'h717A9FB0, i;
    always #2 clk_sys = ~clk_sys;
    sas_sequencer sas_sequencer_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmp_above(cmp_above), .sample_en(sample_en),
        .trial_code(trial_code), .input_select(input_select),
        .converter_power_on(converter_power_on));
    sas_cmp_model sas_cmp_model_i (.clk_sys(clk_sys), .sample_en(sample_en),
        .trial_code(trial_code), .input_select(input_select), .cmp_above(cmp_above));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        avs_address   <= a;
        avs_write     <= w;
        avs_read      <= !w;
        avs_writedata <= {24'h000000, d};
        for (n = 0; n < 50; n++)
        begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0)
                break;
        end
        q = avs_readdata;
        if (n == 50)
        begin
            err_total++;
            complete_run();
        end
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask
    task automatic wait_done;
        int k;
        for (k = 0; k < 40; k++)
        begin
            bus(1'b0, SAS_OFF_CSR, 8'h00);
            if (q[SAS_BIT_DONE] === 1'b1)
                break;
        end
        chk("done", 32'h1, {31'h0, q[SAS_BIT_DONE]});
    endtask
    initial
    begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        bus(1'b0, SAS_OFF_CSR, 8'h00);
        chk("csr_rst", 32'h0, q);
        bus(1'b0, SAS_OFF_RESULT, 8'h00);
        chk("res_rst", 32'h0, q);
        // Saturation corners first, then random levels on every channel
        for (i = 0; i < 18; i++)
        begin
            lv = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($random(seed));
            sas_cmp_model_i.level[i[3:0]] <= lv;
            bus(1'b1, SAS_OFF_CSR, {4'h2, i[3:0]});
            wait_done();
            bus(1'b0, SAS_OFF_RESULT, 8'h00);
            chk("result", {24'h0, lv}, q);
            bus(1'b0, SAS_OFF_CSR, 8'h00);
            chk("done_clr", {28'h2, i[3:0]}, q);
            wait_done();
            bus(1'b0, SAS_OFF_RESULT, 8'h00);
            chk("repeat", {24'h0, lv}, q);
        end
        $display("channel tests done");
        wait_done();
        bus(1'b1, SAS_OFF_CSR, 8'h23);
        bus(1'b0, SAS_OFF_CSR, 8'h00);
        chk("abort", 32'h23, q);
        bus(1'b1, SAS_OFF_CSR, 8'h03);
        repeat (60) @(posedge clk_sys);
        bus(1'b0, SAS_OFF_CSR, 8'h00);
        chk("off", 32'h03, q);
        chk("power", 32'h0, {31'h0, converter_power_on});
        bus(1'b1, SAS_OFF_CSR, 8'h23);
        bus(1'b1, SAS_OFF_POWER, 8'h02);
        wait_done();
        bus(1'b1, SAS_OFF_POWER, 8'h01);
        repeat (20) @(posedge clk_sys);
        chk("halt", 32'h0, {31'h0, converter_power_on});
        bus(1'b1, SAS_OFF_POWER, 8'h00);
        bus(1'b0, SAS_OFF_POWER, 8'h00);
        chk("stab", 32'h1, {31'h0, q[9]});
        $display("power tests done");
        complete_run();
    end
endmodule
`default_nettype wire
